/* verilog/emi_pkg.sv */
// Contract
// [RULE1] 8-bit move takes upper byte from page select
// [RULE2] 8-bit move takes lower byte from index register
// [RULE3] Pointer move uses full 16-bit pointer address
// [RULE4] 4 kB on-chip RAM; flash writes bypass it
// [RULE5] Four ports separate mode, three ports multiplexed
// [RULE6] Pins claimed only during off-chip move
// [RULE7] Input pins undriven during off-chip move
// [RULE8] Pin output type never changed by interface
// [RULE9] Software parks port latches at idle level
// [RULE10] Software follows fixed configuration order
// [RULE11] Port select bit maps interface to pins
// [RULE12] Multiplex bit: 0 shared pins, 1 separate
// [RULE13] Mode 00: all moves on-chip, addresses alias
// [RULE14] Mode 01: split; 8-bit upper byte from latches
// [RULE15] Software sets off-chip page before 8-bit access
// [RULE16] Mode 10: split; 8-bit upper byte from page
// [RULE17] Mode 11: all moves off-chip, RAM hidden
// [RULE18] Latch pulse high and low 1 to 4 cycles
// [RULE19] Config resets 0x03, top two bits zero
// [RULE20] On-chip addresses wrap on 4 kB boundaries
// [RULE21] Multiplexed: address with ALE, then data
// [RULE22] Page select resets to zero
package emi_pkg;

  // Register indices and byte addresses
  localparam logic [7:0]  PAGE_SEL_IDX  = 8'ha2;
  localparam logic [7:0]  MEM_CFG_IDX   = 8'ha3;
  localparam logic [11:0] PAGE_SEL_ADDR = {2'h0, PAGE_SEL_IDX, 2'h0};
  localparam logic [11:0] MEM_CFG_ADDR  = {2'h0, MEM_CFG_IDX, 2'h0};
  localparam int          APB_AW        = 12;

  // Reset values and masks
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] MEM_CFG_RESET  = 8'h03;
  localparam logic [7:0] MEM_CFG_WMASK  = 8'h3f;

  // Configuration field positions
  localparam int CFG_PORT_BIT = 5;
  localparam int CFG_MUX_BIT  = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ALE_LSB  = 0;

  // Memory map modes
  typedef enum logic [1:0] {
    MODE_INT_ONLY = 2'h0,
    MODE_SPLIT_NB = 2'h1,
    MODE_SPLIT_BS = 2'h2,
    MODE_EXT_ONLY = 2'h3
  } emi_mode_t;

  // On-chip RAM size and pin timing defaults
  localparam int XRAM_AW     = 12;
  localparam int SYNC_STAGES = 2;
  localparam int SETUP_CYC   = 1;
  localparam int STROBE_CYC  = 1;
  localparam int HOLD_CYC    = 1;

  // Move sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INT,
    ST_ALE_HI,
    ST_ALE_LO,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_FIN
  } emi_state_t;

endpackage

/* verilog/emi_xram.sv */
module emi_xram #(
  parameter int AW = emi_pkg::XRAM_AW
) (
  input  wire logic          ref_clk,
  input  wire logic          ce,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_ff
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Synchronous single-port byte RAM
  always_ff @(posedge ref_clk) begin
    if (ce && en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_ff <= mem[addr];
    end
  end

endmodule

/* verilog/emi_ctrl.sv */
// Decided for this implementation: the APB register port.
module emi_ctrl #(
  parameter int SETUP_CYC  = emi_pkg::SETUP_CYC,
  parameter int STROBE_CYC = emi_pkg::STROBE_CYC,
  parameter int HOLD_CYC   = emi_pkg::HOLD_CYC
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [emi_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       mov_req,
  input  wire logic                       mov_dptr_form,
  input  wire logic                       mov_write,
  input  wire logic [15:0]                mov_dptr,
  input  wire logic [7:0]                 mov_index,
  input  wire logic [7:0]                 mov_wdata,
  input  wire logic                       flash_wr_en,
  output logic                            mov_ready,
  output logic                            mov_done,
  output logic      [7:0]                 mov_rdata,
  input  wire logic [7:0]                 latch_addr_hi,
  input  wire logic [7:0]                 pin_ad_in,
  output logic      [7:0]                 pin_ad_out,
  output logic                            pin_ad_oe,
  output logic      [7:0]                 pin_addr_lo_out,
  output logic                            pin_addr_lo_oe,
  output logic      [7:0]                 pin_addr_hi_out,
  output logic                            pin_addr_hi_oe,
  output logic                            pin_rd_n,
  output logic                            pin_wr_n,
  output logic                            pin_ale,
  output logic                            pin_ctrl_oe
);

  emi_pkg::emi_state_t state_ff;
  emi_pkg::emi_state_t nxt_state;
  emi_pkg::emi_mode_t  mode;

  logic [7:0]  page_ff;
  logic [7:0]  cfg_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  nxt_cnt;
  logic [7:0]  lim;
  logic [15:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic        wr_ff;
  logic        hi_drv_ff;
  logic        done_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  ad_meta_ff;
  logic [7:0]  ad_sync_ff;
  logic [7:0]  xram_q;
  logic [15:0] eff;
  logic [15:0] sel_addr;
  logic [7:0]  sel_wdata;
  logic        sel_wr;
  logic        sel_hi;
  logic        hi_drv;
  logic        onchip;
  logic        take;
  logic        port_en;
  logic        mux_mode;
  logic [7:0]  ale_w;
  logic        off_ns;
  logic        ale_ns;
  logic        apb_wr;
  logic        apb_setup;
  logic        page_hit;
  logic        cfg_hit;

  // Configuration field decode
  assign port_en  = cfg_ff[emi_pkg::CFG_PORT_BIT];
  assign mux_mode = ~cfg_ff[emi_pkg::CFG_MUX_BIT];  // [RULE12]
  assign mode     = emi_pkg::emi_mode_t'(cfg_ff[emi_pkg::CFG_MODE_LSB +: 2]);
  assign ale_w    = {6'h00, cfg_ff[emi_pkg::CFG_ALE_LSB +: 2]} + 8'h01;

  // APB decode, zero wait states
  assign page_hit  = (paddr == emi_pkg::PAGE_SEL_ADDR);
  assign cfg_hit   = (paddr == emi_pkg::MEM_CFG_ADDR);
  assign apb_setup = psel & ~penable & ce;
  assign apb_wr    = psel & penable & pwrite & ce;
  assign pready    = psel & penable & ce;
  assign prdata    = prdata_ff;
  assign pslverr   = pslverr_ff;

  // Software registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      page_ff <= emi_pkg::PAGE_SEL_RESET;  // [RULE22]
      cfg_ff  <= emi_pkg::MEM_CFG_RESET;   // [RULE19]
    end else if (apb_wr) begin
      if (page_hit) begin
        page_ff <= pwdata[7:0];
      end
      if (cfg_hit) begin
        cfg_ff <= pwdata[7:0] & emi_pkg::MEM_CFG_WMASK;  // [RULE19]
      end
    end
  end

  // Read data and error captured in setup phase
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      pslverr_ff <= ~(page_hit | cfg_hit);
      if (page_hit) begin
        prdata_ff <= {24'h000000, page_ff};
      end else if (cfg_hit) begin
        prdata_ff <= {24'h000000, cfg_ff};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Effective address of a new move
  assign eff = mov_dptr_form ? mov_dptr           // [RULE3]
                             : {page_ff, mov_index};  // [RULE1] [RULE2]

  // On-chip or off-chip steering
  always_comb begin
    case (mode)
      emi_pkg::MODE_INT_ONLY: onchip = 1'b1;               // [RULE13]
      emi_pkg::MODE_SPLIT_NB: onchip = (eff[15:12] == 4'h0);  // [RULE14]
      emi_pkg::MODE_SPLIT_BS: onchip = (eff[15:12] == 4'h0);  // [RULE16]
      emi_pkg::MODE_EXT_ONLY: onchip = 1'b0;               // [RULE17]
      default:                onchip = 1'b1;
    endcase
  end

  // Upper address pins driven by pointer moves and bank select
  assign hi_drv = mov_dptr_form | (mode == emi_pkg::MODE_SPLIT_BS);  // [RULE14]

  assign mov_ready = (state_ff == emi_pkg::ST_IDLE) & ~done_ff;
  assign take      = mov_req & mov_ready & ce;

  // Live request while idle, latched request otherwise
  assign sel_addr  = (state_ff == emi_pkg::ST_IDLE) ? eff : addr_ff;
  assign sel_wdata = (state_ff == emi_pkg::ST_IDLE) ? mov_wdata : wdata_ff;
  assign sel_wr    = (state_ff == emi_pkg::ST_IDLE) ? mov_write : wr_ff;
  assign sel_hi    = (state_ff == emi_pkg::ST_IDLE) ? hi_drv : hi_drv_ff;

  // Phase length of the current state
  always_comb begin
    case (state_ff)
      emi_pkg::ST_ALE_HI: lim = ale_w;  // [RULE18]
      emi_pkg::ST_ALE_LO: lim = ale_w;  // [RULE18]
      emi_pkg::ST_SETUP:  lim = 8'(SETUP_CYC);
      emi_pkg::ST_STROBE: lim = wr_ff ? 8'(STROBE_CYC)
                                     : 8'(STROBE_CYC + emi_pkg::SYNC_STAGES);
      emi_pkg::ST_HOLD:   lim = 8'(HOLD_CYC);
      default:            lim = 8'h01;
    endcase
  end

  // Move sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 8'h01;
    case (state_ff)
      emi_pkg::ST_IDLE: begin
        nxt_cnt = 8'h00;
        if (take) begin
          if (mov_write && flash_wr_en) begin
            nxt_state = emi_pkg::ST_FIN;  // [RULE4]
          end else if (onchip) begin
            nxt_state = emi_pkg::ST_INT;
          end else if (mux_mode) begin
            nxt_state = emi_pkg::ST_ALE_HI;  // [RULE21]
          end else begin
            nxt_state = emi_pkg::ST_SETUP;
          end
        end
      end
      emi_pkg::ST_INT: begin
        nxt_state = emi_pkg::ST_FIN;
      end
      emi_pkg::ST_ALE_HI: begin
        if (cnt_ff == lim - 8'h01) begin
          nxt_state = emi_pkg::ST_ALE_LO;
          nxt_cnt   = 8'h00;
        end
      end
      emi_pkg::ST_ALE_LO: begin
        if (cnt_ff == lim - 8'h01) begin
          nxt_state = emi_pkg::ST_SETUP;
          nxt_cnt   = 8'h00;
        end
      end
      emi_pkg::ST_SETUP: begin
        if (cnt_ff == lim - 8'h01) begin
          nxt_state = emi_pkg::ST_STROBE;
          nxt_cnt   = 8'h00;
        end
      end
      emi_pkg::ST_STROBE: begin
        if (cnt_ff == lim - 8'h01) begin
          nxt_state = emi_pkg::ST_HOLD;
          nxt_cnt   = 8'h00;
        end
      end
      emi_pkg::ST_HOLD: begin
        if (cnt_ff == lim - 8'h01) begin
          nxt_state = emi_pkg::ST_FIN;
          nxt_cnt   = 8'h00;
        end
      end
      emi_pkg::ST_FIN: begin
        nxt_state = emi_pkg::ST_IDLE;
        nxt_cnt   = 8'h00;
      end
      default: begin
        nxt_state = emi_pkg::ST_IDLE;
        nxt_cnt   = 8'h00;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= emi_pkg::ST_IDLE;
      cnt_ff   <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Request latch
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_ff   <= 16'h0000;
      wdata_ff  <= 8'h00;
      wr_ff     <= 1'b0;
      hi_drv_ff <= 1'b0;
    end else if (take) begin
      addr_ff   <= eff;
      wdata_ff  <= mov_wdata;
      wr_ff     <= mov_write;
      hi_drv_ff <= hi_drv;
    end
  end

  // On-chip RAM, address folded to 4 kB
  emi_xram #(
    .AW(emi_pkg::XRAM_AW)
  ) u_xram (
    .ref_clk  (ref_clk),
    .ce       (ce),
    .en       (state_ff == emi_pkg::ST_INT),
    .we       (wr_ff),
    .addr     (addr_ff[emi_pkg::XRAM_AW-1:0]),  // [RULE20] [RULE4]
    .wdata    (wdata_ff),
    .rdata_ff (xram_q)
  );

  // Pin data synchroniser
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ad_meta_ff <= 8'h00;
      ad_sync_ff <= 8'h00;
    end else if (ce) begin
      ad_meta_ff <= pin_ad_in;
      ad_sync_ff <= ad_meta_ff;
    end
  end

  // Read data and completion pulse
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
      done_ff  <= 1'b0;
    end else if (ce) begin
      done_ff <= (state_ff == emi_pkg::ST_FIN);
      if (state_ff == emi_pkg::ST_STROBE && !wr_ff &&
          cnt_ff == lim - 8'h01) begin
        rdata_ff <= ad_sync_ff;  // [RULE21]
      end else if (state_ff == emi_pkg::ST_FIN && nxt_state ==
                   emi_pkg::ST_IDLE && addr_ff[15:12] == 4'h0 &&
                   mode != emi_pkg::MODE_EXT_ONLY && !wr_ff) begin
        rdata_ff <= xram_q;
      end else if (state_ff == emi_pkg::ST_FIN && mode ==
                   emi_pkg::MODE_INT_ONLY && !wr_ff) begin
        rdata_ff <= xram_q;
      end
    end
  end

  assign mov_done  = done_ff;
  assign mov_rdata = rdata_ff;

  // Off-chip phase of the coming cycle
  assign off_ns = (nxt_state == emi_pkg::ST_ALE_HI) |
                  (nxt_state == emi_pkg::ST_ALE_LO) |
                  (nxt_state == emi_pkg::ST_SETUP)  |
                  (nxt_state == emi_pkg::ST_STROBE) |
                  (nxt_state == emi_pkg::ST_HOLD);
  assign ale_ns = (nxt_state == emi_pkg::ST_ALE_HI) |
                  (nxt_state == emi_pkg::ST_ALE_LO);

  // Pin drivers; output type stays with the port logic
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_ctrl_oe     <= 1'b0;
      pin_ale         <= 1'b0;
      pin_rd_n        <= 1'b1;
      pin_wr_n        <= 1'b1;
      pin_addr_lo_oe  <= 1'b0;
      pin_addr_hi_oe  <= 1'b0;
      pin_ad_oe       <= 1'b0;
      pin_addr_lo_out <= 8'h00;
      pin_addr_hi_out <= 8'h00;
      pin_ad_out      <= 8'h00;
    end else if (ce) begin
      pin_ctrl_oe     <= off_ns & port_en;  // [RULE6] [RULE11] [RULE8]
      pin_ale         <= nxt_state == emi_pkg::ST_ALE_HI;  // [RULE18]
      pin_rd_n        <= ~(nxt_state == emi_pkg::ST_STROBE & ~sel_wr);
      pin_wr_n        <= ~(nxt_state == emi_pkg::ST_STROBE & sel_wr);
      pin_addr_lo_oe  <= off_ns & port_en & ~mux_mode;  // [RULE5]
      pin_addr_hi_oe  <= off_ns & port_en & sel_hi;     // [RULE14]
      pin_addr_lo_out <= sel_addr[7:0];
      pin_addr_hi_out <= sel_hi ? sel_addr[15:8] : latch_addr_hi;
      pin_ad_oe       <= off_ns & port_en &
                         ((mux_mode & ale_ns) | sel_wr);  // [RULE7]
      pin_ad_out      <= (mux_mode & ale_ns) ? sel_addr[7:0]  // [RULE21]
                                             : sel_wdata;
    end
  end

  // Helper: length of the last latch pulse level
  logic [7:0] ale_len_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ale_len_ff <= 8'h00;
    end else if (ce) begin
      if (pin_ale != (nxt_state == emi_pkg::ST_ALE_HI)) begin
        ale_len_ff <= 8'h01;
      end else begin
        ale_len_ff <= ale_len_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Assertions
  a_cfg_top_zero: assert property (cfg_ff[7:6] == 2'h0)  // [RULE19]
    else $error("config top bits not zero");
  a_claim_only_off: assert property (  // [RULE6]
    pin_ctrl_oe |-> (state_ff != emi_pkg::ST_IDLE &&
                     state_ff != emi_pkg::ST_INT &&
                     state_ff != emi_pkg::ST_FIN))
    else $error("pins claimed outside off-chip move");
  a_read_undriven: assert property (  // [RULE7]
    (state_ff == emi_pkg::ST_STROBE && !wr_ff) |-> !pin_ad_oe)
    else $error("data pins driven during read");
  a_mux_no_lo: assert property (pin_addr_lo_oe |-> !mux_mode)  // [RULE5]
    else $error("low address port claimed in mux mode");
  a_port_sel_gate: assert property (pin_ctrl_oe |-> port_en)  // [RULE11]
    else $error("pins claimed while unmapped");
  a_int_only_on: assert property (  // [RULE13]
    (take && mode == emi_pkg::MODE_INT_ONLY && !(mov_write && flash_wr_en))
    |=> state_ff == emi_pkg::ST_INT)
    else $error("internal mode move went off-chip");
  a_ext_only_off: assert property (  // [RULE17]
    (take && mode == emi_pkg::MODE_EXT_ONLY) |=> state_ff != emi_pkg::ST_INT)
    else $error("external mode move went on-chip");
  a_ale_width: assert property (  // [RULE18]
    (ce && state_ff == emi_pkg::ST_ALE_LO && nxt_state == emi_pkg::ST_SETUP)
    |-> ale_len_ff == ale_w)
    else $error("latch pulse low width wrong");
  a_page_addr: assert property (  // [RULE1]
    (take && !mov_dptr_form) |=> addr_ff == {$past(page_ff), $past(mov_index)})
    else $error("8-bit effective address wrong");
  a_hi_from_latch: assert property (  // [RULE14]
    (take && !mov_dptr_form && mode == emi_pkg::MODE_SPLIT_NB)
    |=> !pin_addr_hi_oe)
    else $error("upper address driven in no-bank mode");

  c_mux_read: cover property (take && !mov_write && mux_mode && !onchip);
  c_sep_write: cover property (take && mov_write && !mux_mode && !onchip);
  c_onchip: cover property (state_ff == emi_pkg::ST_INT);

endmodule

/* sim/emi_sram_model.sv */
module emi_sram_model (
  input  wire logic       ref_clk,
  input  wire logic       mux,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic [7:0] lo_out,
  input  wire logic       lo_oe,
  input  wire logic [7:0] hi_out,
  input  wire logic       hi_oe,
  input  wire logic [7:0] hi_latch,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       ale,
  input  wire logic       ctrl_oe,
  output logic      [7:0] ad_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat_ff;
  logic [7:0]  last_ff = 8'h5a;
  logic [15:0] addr;
  logic        rd;
  logic        wr;

  // Strobes only count while the control pins are claimed
  assign rd = ctrl_oe && !rd_n;
  assign wr = ctrl_oe && !wr_n;
  // Unclaimed upper pins show the port latch
  assign addr = {hi_oe ? hi_out : hi_latch,
                 mux ? lat_ff : (lo_oe ? lo_out : 8'hff)};

  // Released bus shows the inverse of its last level
  always_comb begin
    if (ad_oe) ad_wire = ad_out;
    else if (rd) ad_wire = mem[addr];
    else ad_wire = ~last_ff;
  end

  // Address latch and write capture
  always @(posedge ref_clk) begin
    last_ff <= ad_wire;
    if (ale && ctrl_oe) lat_ff <= ad_wire;
    if (wr) mem[addr] <= ad_wire;
  end
endmodule

/* sim/external_data_memory_interface_bench.sv */
module external_data_memory_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic       rd;
    logic [7:0] d;
    int         lat;
    int         ale;
    logic [2:0] clm;
  } emi_exp_t;
  typedef struct {logic wr; logic err; logic [7:0] d;} emi_apb_t;
  logic        ref_clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, mov_ready, mov_done;
  logic        mov_req = 1'b0, mov_dptr_form = 1'b0, mov_write = 1'b0;
  logic        flash_wr_en = 1'b0;
  logic [15:0] mov_dptr = 16'h0;
  logic [7:0]  mov_index = 8'h0, mov_wdata = 8'h0, pin_ad_in, mov_rdata;
  logic [7:0]  latch_addr_hi = 8'hff;
  logic [7:0]  pin_ad_out, pin_addr_lo_out, pin_addr_hi_out;
  logic        pin_ad_oe, pin_addr_lo_oe, pin_addr_hi_oe;
  logic        pin_rd_n, pin_wr_n, pin_ale, pin_ctrl_oe;
  logic [7:0]  cfg = 8'h03, page = 8'h00;
  logic [2:0]  seen = 3'h0;
  int          miscompares = 0, total_checks = 0, cnt = 0, ale_n = 0;
  int          stall = 0;
  emi_exp_t    mq[$];
  emi_apb_t    aq[$];

  always #2 ref_clk = ~ref_clk;

  emi_ctrl u_dut (.ref_clk, .reset, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mov_req, .mov_dptr_form,
    .mov_write, .mov_dptr, .mov_index, .mov_wdata, .flash_wr_en,
    .mov_ready, .mov_done, .mov_rdata, .latch_addr_hi, .pin_ad_in,
    .pin_ad_out, .pin_ad_oe, .pin_addr_lo_out, .pin_addr_lo_oe,
    .pin_addr_hi_out, .pin_addr_hi_oe, .pin_rd_n, .pin_wr_n, .pin_ale,
    .pin_ctrl_oe);

  emi_sram_model u_mem (.ref_clk, .mux(!cfg[4]), .ad_out(pin_ad_out),
    .ad_oe(pin_ad_oe), .lo_out(pin_addr_lo_out), .lo_oe(pin_addr_lo_oe),
    .hi_out(pin_addr_hi_out), .hi_oe(pin_addr_hi_oe),
    .hi_latch(latch_addr_hi), .rd_n(pin_rd_n), .wr_n(pin_wr_n),
    .ale(pin_ale), .ctrl_oe(pin_ctrl_oe), .ad_wire(pin_ad_in));

  task automatic chk(input logic [31:0] got, want);
    total_checks++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, got, want);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, e, input logic err);
    aq.push_back('{wr, err, e});
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setcfg(input logic [7:0] v);
    apb(1'b1, emi_pkg::MEM_CFG_ADDR, v, 8'h00, 1'b0);
    cfg = v;
  endtask

  task automatic setpg(input logic [7:0] v);
    apb(1'b1, emi_pkg::PAGE_SEL_ADDR, v, 8'h00, 1'b0);
    page = v;
  endtask

  task automatic mv(input logic wr, dp, input logic [15:0] a,
                    input logic [7:0] d, lh);
    logic [15:0] ea;
    logic        on, c, mx;
    int          lat, al;
    // Note taken after the edge so inputs set just before have settled
    @(posedge ref_clk);
    ea = dp ? a : {page, a[7:0]};
    mx = !cfg[4];
    al = cfg[1:0];
    on = cfg[3:2] == 2'h0 || (cfg[3:2] != 2'h3 && ea[15:12] == 4'h0);
    c = !on && !(wr && flash_wr_en) && cfg[5];
    lat = (wr && flash_wr_en) ? 2 : on ? 3 : (wr ? 5 : 7) + (mx ? 2*al+2 : 0);
    mq.push_back('{!wr, d, lat + stall, (c && mx) ? al+1 : 0,
                   {c, c && cfg[4], c && (dp || cfg[3:2] == 2'h2)}});
    mov_req <= 1'b1;
    mov_write <= wr;
    mov_dptr_form <= dp;
    mov_dptr <= a;
    mov_index <= a[7:0];
    mov_wdata <= wr ? d : 8'($urandom);
    latch_addr_hi <= lh;
    do @(posedge ref_clk); while (!mov_done);
    mov_req <= 1'b0;
  endtask

  // Register transfer error and read data against the oldest note
  always @(posedge ref_clk) if (psel && penable && pready) begin
    emi_apb_t x;
    x = aq.pop_front();
    chk(pslverr, x.err);
    if (!x.wr) chk(prdata, {24'h0, x.d});
  end

  // Move timing, pin claims and read data
  always @(posedge ref_clk) begin
    emi_exp_t x;
    if (mov_req && mov_ready && ce) begin
      cnt = 0;
      ale_n = 0;
      seen = 3'h0;
    end else begin
      cnt++;
      ale_n += int'(pin_ale && pin_ctrl_oe);
      seen |= {pin_ctrl_oe, pin_addr_lo_oe, pin_addr_hi_oe};
    end
    chk(pin_ad_oe && !pin_rd_n, 1'b0);
    if (mov_done) begin
      x = mq.pop_front();
      chk(cnt, x.lat);
      chk(ale_n, x.ale);
      chk(seen, x.clm);
      chk({pin_ad_oe, pin_addr_lo_oe}, 2'h0);
      chk({pin_addr_hi_oe, pin_ctrl_oe}, 2'h0);
      if (x.rd) chk(mov_rdata, x.d);
    end
  end

  // Run guard
  initial begin
    #200000;
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    logic [15:0] a;
    logic [7:0]  d, hb;
    logic        off;
    void'($urandom(32'h373b2a75));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    apb(1'b0, emi_pkg::PAGE_SEL_ADDR, 8'h00, 8'h00, 1'b0);
    apb(1'b0, emi_pkg::MEM_CFG_ADDR, 8'h00, 8'h03, 1'b0);
    apb(1'b0, 12'h290, 8'h00, 8'h00, 1'b1);
    setcfg(8'hff);
    apb(1'b0, emi_pkg::MEM_CFG_ADDR, 8'h00, 8'h3f, 1'b0);
    setcfg(8'h00);
    d = 8'($urandom);
    mv(1'b1, 1'b1, 16'h1abc, d, 8'hff);
    mv(1'b0, 1'b1, 16'h0abc, d, 8'hff);
    setpg(8'h3a);
    mv(1'b0, 1'b0, 16'h00bc, d, 8'hff);
    flash_wr_en <= 1'b1;
    mv(1'b1, 1'b1, 16'h0abc, ~d, 8'hff);
    flash_wr_en <= 1'b0;
    mv(1'b0, 1'b1, 16'h0abc, d, 8'hff);
    for (int m = 1; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        setcfg({3'h1, s[0], m[1:0], 2'($urandom)});
        for (int r = 0; r < 2; r++) begin
          a = 16'($urandom);
          if (m == 3 || r == 1) a[15:12] = 4'h0;
          d = 8'($urandom);
          hb = a[15:8];
          off = m == 3 || a[15:12] != 4'h0;
          mv(1'b1, 1'b1, a, d, ~hb);
          if (off) chk(u_mem.mem[a], d);
          setpg((m == 2 || !off) ? hb : hb ^ 8'h01);
          mv(1'b0, 1'b0, a, d, (m == 2) ? ~hb : hb);
        end
      end
    end
    // Clock enable dropped for four edges in mid-move stretches it
    setcfg(8'h3c);
    stall = 4;
    fork
      mv(1'b1, 1'b1, 16'h0055, 8'hc3, 8'hff);
      begin
        repeat (3) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    stall = 0;
    setcfg(8'h1c);
    mv(1'b1, 1'b1, 16'h0055, 8'h3c, 8'hff);
    chk(u_mem.mem[16'h0055], 8'hc3);
    results();
  end
endmodule
